// File: shared/axis_reference_search_consts.vh
// Register map, field positions, reset values and command codes of the axis reference search
// Summary of operation
// - Seek phase runs at the search velocity until the switch is first hit.
// - Creep off the switch, re-enter slowly, reference is midway between both points.
// - End-switch automatic stop enables have no effect while a search runs.
// - One command, opcode 13, starts, stops and polls the search state machine.
// - Search procedure chosen by the mode setting; base modes are 1 to 8.
// - Mode 1 searches the left end switch; 65 searches the right one.
// - Mode 2: right then left, left is zero, switch distance reported.
// - Mode 66: left first, then right end switch used as zero.
// - Mode 3: right, then middle of left switch is zero; 67 mirrors.
// - Mode 4: middle of left switch is zero; 68 uses right switch.
// - Mode 5: home search negative, reverse when the left limit is hit.
// - Mode 6: home search positive, reverse when the right limit is hit.
// - Mode 7: home search positive, limits ignored, middle of home is zero.
// - Mode 8: home search negative, limits ignored, middle of home is zero.
// - Modes 133 to 136 invert the home switch polarity.
// - Full steps per revolution setting, default 200.
// - Encoder counts scaled by counts per revolution and full steps to microsteps.
// - Encoder position readable and writable, cleared when a search completes.
// - Motor halted when position deviation exceeds a nonzero configured maximum.
`ifndef AXIS_REFERENCE_SEARCH_CONSTS_VH
`define AXIS_REFERENCE_SEARCH_CONSTS_VH

`define ADR_COMMAND      6'h00
`define ADR_STATUS       6'h01
`define ADR_MODE         6'h02
`define ADR_SEARCH_VEL   6'h03
`define ADR_CAL_VEL      6'h04
`define ADR_SWITCH_DIST  6'h05
`define ADR_FULL_STEPS   6'h06
`define ADR_ENC_CPR      6'h07
`define ADR_ENC_POS      6'h08
`define ADR_MAX_DEV      6'h09
`define ADR_STOP_ENABLE  6'h0a

`define CMD_OPCODE       8'h0d
`define CMD_START        2'h0
`define CMD_STOP         2'h1
`define CMD_STATUS       2'h2

`define MODE_MIRROR_BIT  6
`define MODE_HPOL_BIT    7

`define TGT_LEFT         2'h0
`define TGT_RIGHT        2'h1
`define TGT_HOME         2'h2

`define MICROSTEP_SHIFT  8
`define RST_MODE         8'h01
`define RST_SEARCH_VEL   32'h0000_1000
`define RST_CAL_VEL      32'h0000_0100
`define RST_FULL_STEPS   16'h00c8
`define RST_ENC_CPR      32'h0000_c800
`define RST_MAX_DEV      32'h0000_0000

`endif

// File: verilog/axis_reference_search.v
// Reference search state machine, encoder scaling and deviation stop for one axis
`timescale 1ns/1ps
`include "axis_reference_search_consts.vh"

module axis_reference_search (
    input  wire        sys_clk,         // 25 MHz module clock
    input  wire        rst_n,           // Asynchronous reset, active low
    input  wire        wb_cyc_i,        // Wishbone cycle
    input  wire        wb_stb_i,        // Wishbone strobe
    input  wire        wb_we_i,         // Wishbone write enable
    input  wire [7:0]  wb_adr_i,        // Wishbone byte address
    input  wire [3:0]  wb_sel_i,        // Wishbone byte selects
    input  wire [31:0] wb_dat_i,        // Wishbone write data
    output reg  [31:0] wb_dat_o,        // Wishbone read data
    output reg         wb_ack_o,        // Wishbone acknowledge
    input  wire        stop_left,       // Left end switch, high when active
    input  wire        stop_right,      // Right end switch, high when active
    input  wire        home_switch,     // Home switch, high when active
    input  wire [31:0] actual_pos,      // Motor position in microsteps
    input  wire        enc_step,        // One encoder count this cycle
    input  wire        enc_up,          // Count direction, high counts up
    output reg  [31:0] motor_vel,       // Velocity demand
    output reg         motor_dir,       // High moves positive
    output reg         motor_run,       // Velocity demand valid
    output reg         motor_halt,      // Stop motor now
    output reg         pos_load,        // Pulse: load pos_load_value into the motor position
    output reg  [31:0] pos_load_value   // New motor position at pos_load
);

    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_SEEK = 7'h02;
    localparam [6:0] ST_OFF  = 7'h04;
    localparam [6:0] ST_IN   = 7'h08;
    localparam [6:0] ST_THRU = 7'h10;
    localparam [6:0] ST_EDGE = 7'h20;
    localparam [6:0] ST_LOAD = 7'h40;

    reg  [6:0]  state;
    reg  [7:0]  mode;
    reg  [31:0] search_vel;
    reg  [31:0] cal_vel;
    reg  [31:0] switch_dist;
    reg  [15:0] full_steps;
    reg  [31:0] enc_cpr;
    reg  [31:0] enc_pos;
    reg  [31:0] enc_acc;
    reg  [31:0] max_dev;
    reg  [1:0]  stop_enable;
    reg  [1:0]  tgt;
    reg         sdir;
    reg         second;
    reg         done;
    reg         mode_err;
    reg         dev_err;
    reg  [31:0] pa;
    reg  [31:0] pb;
    reg  [31:0] p_first;
    reg  [31:0] edge_pos;

    // Bus decode
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr   = bus_req & wb_we_i;
    wire [5:0]  widx     = wb_adr_i[7:2];
    wire        cmd_wr   = bus_wr && widx == `ADR_COMMAND && wb_sel_i[1:0] == 2'h3
                           && wb_dat_i[7:0] == `CMD_OPCODE;
    wire        cmd_start = cmd_wr && wb_dat_i[9:8] == `CMD_START;
    wire        cmd_stop  = cmd_wr && wb_dat_i[9:8] == `CMD_STOP;
    wire        enc_wr   = bus_wr && widx == `ADR_ENC_POS;
    wire        running  = ~state[0];

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // Mode decode: low six bits base, bit 6 mirrors sides, bit 7 inverts home polarity
    wire [5:0]  base     = mode[5:0];
    wire        mirror   = mode[`MODE_MIRROR_BIT];
    wire        hpol     = mode[`MODE_HPOL_BIT];
    wire        mode_ok  = base >= 6'd1 && base <= 6'd8
                           && !(mirror && base > 6'd4) && !(hpol && base < 6'd5);
    wire        home_mode = base >= 6'd5;
    wire        two_sw   = base == 6'd2 || base == 6'd3;
    wire        both_fin = base == 6'd3 || base == 6'd4 || base == 6'd7 || base == 6'd8;
    wire        both_now = both_fin && (second || !two_sw);
    reg  [1:0]  first_tgt;
    reg         first_dir;

    always @* begin
        first_tgt = `TGT_LEFT;
        first_dir = 1'b0;
        case (base)
            6'd1, 6'd4: begin
                first_tgt = mirror ? `TGT_RIGHT : `TGT_LEFT;
                first_dir = mirror;
            end
            6'd2, 6'd3: begin
                first_tgt = mirror ? `TGT_LEFT : `TGT_RIGHT;
                first_dir = ~mirror;
            end
            6'd6, 6'd7: begin
                first_tgt = `TGT_HOME;
                first_dir = 1'b1;
            end
            6'd5, 6'd8: begin
                first_tgt = `TGT_HOME;
                first_dir = 1'b0;
            end
            default: begin
                first_tgt = `TGT_LEFT;
                first_dir = 1'b0;
            end
        endcase
    end

    wire home_act = home_switch ^ hpol;
    wire hit = (tgt == `TGT_LEFT)  ? stop_left :
               (tgt == `TGT_RIGHT) ? stop_right : home_act;

    wire [32:0] edge_sum = {pa[31], pa} + {pb[31], pb};
    wire [31:0] mid_pos  = edge_sum[32:1];
    wire [31:0] dist_raw = edge_pos - p_first;
    wire [31:0] dist_abs = dist_raw[31] ? (32'h0 - dist_raw) : dist_raw;

    // Search state machine
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            tgt         <= `TGT_LEFT;
            sdir        <= 1'b0;
            second      <= 1'b0;
            done        <= 1'b0;
            mode_err    <= 1'b0;
            pa          <= 32'h0;
            pb          <= 32'h0;
            p_first     <= 32'h0;
            edge_pos    <= 32'h0;
            switch_dist <= 32'h0;
        end else if (cmd_stop || (running && dev_err)) begin
            state <= ST_IDLE;
        end else if (cmd_start) begin
            done   <= 1'b0;
            second <= 1'b0;
            if (mode_ok) begin
                mode_err <= 1'b0;
                tgt      <= first_tgt;
                sdir     <= first_dir;
                state    <= ST_SEEK;
            end else begin
                mode_err <= 1'b1;
                state    <= ST_IDLE;
            end
        end else begin
            case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_SEEK: begin
                    if (hit) begin
                        state <= ST_OFF;
                    end else if (base == 6'd5 && !sdir && stop_left) begin
                        sdir <= 1'b1;
                    end else if (base == 6'd6 && sdir && stop_right) begin
                        sdir <= 1'b0;
                    end
                end
                ST_OFF: begin
                    if (!hit) begin
                        pa    <= actual_pos;
                        state <= ST_IN;
                    end
                end
                ST_IN: begin
                    if (hit) begin
                        pb    <= actual_pos;
                        state <= both_now ? ST_THRU : ST_EDGE;
                    end
                end
                ST_THRU: begin
                    if (!hit) begin
                        pa    <= actual_pos;
                        state <= ST_EDGE;
                    end
                end
                ST_EDGE: begin
                    edge_pos <= mid_pos;
                    if (two_sw && !second) begin
                        p_first <= mid_pos;
                        second  <= 1'b1;
                        tgt     <= (tgt == `TGT_LEFT) ? `TGT_RIGHT : `TGT_LEFT;
                        sdir    <= ~sdir;
                        state   <= ST_SEEK;
                    end else begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (two_sw)
                        switch_dist <= dist_abs;
                    done  <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Motion demand; the creep-off phase runs against the search direction
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_vel      <= 32'h0;
            motor_dir      <= 1'b0;
            motor_run      <= 1'b0;
            motor_halt     <= 1'b0;
            pos_load       <= 1'b0;
            pos_load_value <= 32'h0;
        end else begin
            motor_run <= state[1] | state[2] | state[3] | state[4];
            motor_vel <= state[1] ? search_vel : cal_vel;
            motor_dir <= state[2] ? ~sdir : sdir;
            // Limits only stop the motor outside a search
            motor_halt <= dev_err
                          || (!running && ((stop_enable[0] && stop_left)
                                           || (stop_enable[1] && stop_right)));
            pos_load       <= state[6];
            // Held after the load so the value stays readable once the zero is applied
            if (state[6])
                pos_load_value <= actual_pos - edge_pos;
        end
    end

    // Encoder scaling: a residue accumulator avoids a divider
    wire [31:0] enc_inc  = {8'h0, full_steps, {`MICROSTEP_SHIFT{1'b0}}};
    reg  [31:0] next_acc;
    reg  [31:0] next_enc;
    reg  [31:0] acc_step;

    always @* begin
        acc_step = enc_acc;
        if (enc_step)
            acc_step = enc_up ? enc_acc + enc_inc : enc_acc - enc_inc;
        next_acc = acc_step;
        next_enc = enc_pos;
        if (enc_cpr != 32'h0) begin
            if (!acc_step[31] && acc_step >= enc_cpr) begin
                next_acc = acc_step - enc_cpr;
                next_enc = enc_pos + 32'h1;
            end else if (acc_step[31] && (32'h0 - acc_step) >= enc_cpr) begin
                next_acc = acc_step + enc_cpr;
                next_enc = enc_pos - 32'h1;
            end
        end
    end

    wire [31:0] fs_merged = merge({16'h0, full_steps}, wb_dat_i, wb_sel_i);
    wire [31:0] dev_raw = actual_pos - enc_pos;
    wire [31:0] dev_abs = dev_raw[31] ? (32'h0 - dev_raw) : dev_raw;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_pos <= 32'h0;
            enc_acc <= 32'h0;
            dev_err <= 1'b0;
        end else begin
            if (enc_wr) begin
                enc_pos <= merge(enc_pos, wb_dat_i, wb_sel_i);
                enc_acc <= 32'h0;
            end else if (state[6]) begin
                enc_pos <= 32'h0;
                enc_acc <= 32'h0;
            end else begin
                enc_pos <= next_enc;
                enc_acc <= next_acc;
            end
            // A new excess wins over a clear in the same cycle
            if (max_dev != 32'h0 && dev_abs > max_dev)
                dev_err <= 1'b1;
            else if (cmd_start || cmd_stop)
                dev_err <= 1'b0;
        end
    end

    // Setting registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode        <= `RST_MODE;
            search_vel  <= `RST_SEARCH_VEL;
            cal_vel     <= `RST_CAL_VEL;
            full_steps  <= `RST_FULL_STEPS;
            enc_cpr     <= `RST_ENC_CPR;
            max_dev     <= `RST_MAX_DEV;
            stop_enable <= 2'h0;
        end else if (bus_wr) begin
            case (widx)
                `ADR_MODE:        if (wb_sel_i[0]) mode <= wb_dat_i[7:0];
                `ADR_SEARCH_VEL:  search_vel <= merge(search_vel, wb_dat_i, wb_sel_i);
                `ADR_CAL_VEL:     cal_vel <= merge(cal_vel, wb_dat_i, wb_sel_i);
                `ADR_FULL_STEPS:  full_steps <= fs_merged[15:0];
                `ADR_ENC_CPR:     enc_cpr <= merge(enc_cpr, wb_dat_i, wb_sel_i);
                `ADR_MAX_DEV:     max_dev <= merge(max_dev, wb_dat_i, wb_sel_i);
                `ADR_STOP_ENABLE: if (wb_sel_i[0]) stop_enable <= wb_dat_i[1:0];
                default:          mode <= mode;
            endcase
        end
    end

    // Read mux and single-wait acknowledge; unmapped words read zero
    wire [31:0] status_word = {21'h0, state, dev_err, mode_err, done, running};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (widx)
                    `ADR_COMMAND:     wb_dat_o <= status_word;
                    `ADR_STATUS:      wb_dat_o <= status_word;
                    `ADR_MODE:        wb_dat_o <= {24'h0, mode};
                    `ADR_SEARCH_VEL:  wb_dat_o <= search_vel;
                    `ADR_CAL_VEL:     wb_dat_o <= cal_vel;
                    `ADR_SWITCH_DIST: wb_dat_o <= switch_dist;
                    `ADR_FULL_STEPS:  wb_dat_o <= {16'h0, full_steps};
                    `ADR_ENC_CPR:     wb_dat_o <= enc_cpr;
                    `ADR_ENC_POS:     wb_dat_o <= enc_pos;
                    `ADR_MAX_DEV:     wb_dat_o <= max_dev;
                    `ADR_STOP_ENABLE: wb_dat_o <= {30'h0, stop_enable};
                    default:          wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule // axis_reference_search

// File: tb/axis_search_monitor.sv
// Port checker for the axis reference search
`timescale 1ns/1ps
`include "axis_reference_search_consts.vh"
module axis_search_monitor (
    input wire        sys_clk,    // Clock
    input wire        rst_n,      // Reset, active low
    input wire        wb_cyc_i,   // Bus cycle
    input wire        wb_stb_i,   // Bus strobe
    input wire        wb_ack_o,   // Bus ack
    input wire        stop_left,  // Left switch
    input wire        motor_run,  // Moving
    input wire        motor_dir,  // Direction
    input wire        motor_halt, // Halt
    input wire [31:0] motor_vel,  // Velocity
    input wire        pos_load    // Zero load
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    halt_ignored_a: assert property (motor_run |-> !motor_halt)
        else $error("halt raised during search");
    load_pulse_a: assert property (pos_load |=> !pos_load)
        else $error("zero load longer than one cycle");
    load_still_a: assert property (pos_load |-> !motor_run)
        else $error("zero loaded while moving");
    creep_back_a: assert property (($rose(stop_left) && motor_run && !motor_dir)
        |-> ##[1:3] (motor_dir || !motor_run))
        else $error("no reversal after switch hit");
    cal_speed_a: assert property (($rose(motor_dir) && motor_run && $past(motor_run) && stop_left)
        |-> motor_vel == `RST_CAL_VEL)
        else $error("creep not at calibration velocity");
    seek_speed_a: assert property ($rose(motor_run) |-> motor_vel == `RST_SEARCH_VEL)
        else $error("seek not at search velocity");
endmodule // axis_search_monitor

bind axis_reference_search axis_search_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stop_left(stop_left),
    .motor_run(motor_run), .motor_dir(motor_dir), .motor_halt(motor_halt),
    .motor_vel(motor_vel), .pos_load(pos_load));

// File: tb/axis_stage_model.sv
// Behavioural linear stage with end switches, home switch and encoder
`timescale 1ns/1ps
module axis_stage_model #(
    parameter integer LEFT_AT  = -20, // Left switch engages at or below
    parameter integer RIGHT_AT = 20,  // Right switch engages at or above
    parameter integer HYST     = 4,   // Travel needed to release a switch
    parameter integer STEP_DIV = 8    // Cycles per microstep
) (
    input  wire        sys_clk,        // Clock
    input  wire        rst_n,          // Reset, active low
    input  wire        motor_run,      // Move demand
    input  wire        motor_dir,      // High moves positive
    input  wire        pos_load,       // Load new position
    input  wire [31:0] pos_load_value, // Position to load
    output reg         stop_left,      // Left end switch
    output reg         stop_right,     // Right end switch
    output wire        home_switch,    // Home switch
    output wire [31:0] actual_pos,     // Position seen by the block
    output reg         enc_step,       // Encoder count
    output reg         enc_up          // Encoder direction
);
    integer phys;
    integer offs;
    integer div;
    assign actual_pos = phys - offs;
    assign home_switch = (phys >= 40) && (phys <= 44);
    // Slow stepping lets the block react well inside one step, so switch points are exact
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phys <= 0;
            offs <= 0;
            div <= 0;
            enc_step <= 1'b0;
            enc_up <= 1'b0;
            stop_left <= 1'b0;
            stop_right <= 1'b0;
        end else begin
            enc_step <= 1'b0;
            div <= (div == STEP_DIV - 1) ? 0 : div + 1;
            if (motor_run && div == STEP_DIV - 1) begin
                phys <= motor_dir ? phys + 1 : phys - 1;
                enc_step <= 1'b1;
                enc_up <= motor_dir;
            end
            if (pos_load)
                offs <= phys - $signed(pos_load_value);
            // Lever switches release only after some travel back
            if (phys <= LEFT_AT)
                stop_left <= 1'b1;
            else if (phys >= LEFT_AT + HYST)
                stop_left <= 1'b0;
            if (phys >= RIGHT_AT)
                stop_right <= 1'b1;
            else if (phys <= RIGHT_AT - HYST)
                stop_right <= 1'b0;
        end
    end
endmodule // axis_stage_model

// File: tb/tb_top.sv
// Register-level tests of the axis reference search
`timescale 1ns/1ps
`include "axis_reference_search_consts.vh"
module tb_top;
    localparam [7:0] dir_tab = 8'b0110_0110;
    reg         sys_clk;
    reg         rst_n;
    reg         wb_cyc_i;
    reg         wb_stb_i;
    reg         wb_we_i;
    reg  [7:0]  wb_adr_i;
    reg  [3:0]  wb_sel_i;
    reg  [31:0] wb_dat_i;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire        stop_left;
    wire        stop_right;
    wire        home_switch;
    wire [31:0] actual_pos;
    wire        enc_step;
    wire        enc_up;
    wire [31:0] motor_vel;
    wire        motor_dir;
    wire        motor_run;
    wire        motor_halt;
    wire        pos_load;
    wire [31:0] pos_load_value;
    reg  [31:0] rd;
    integer     n_fail;
    integer     n_checks;
    integer     p0;
    integer     i;
    integer     b;
    integer     v;

    axis_reference_search i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_left(stop_left),
        .stop_right(stop_right), .home_switch(home_switch), .actual_pos(actual_pos),
        .enc_step(enc_step), .enc_up(enc_up), .motor_vel(motor_vel), .motor_dir(motor_dir),
        .motor_run(motor_run), .motor_halt(motor_halt), .pos_load(pos_load),
        .pos_load_value(pos_load_value));
    axis_stage_model i_axis (.sys_clk(sys_clk), .rst_n(rst_n), .motor_run(motor_run),
        .motor_dir(motor_dir), .pos_load(pos_load), .pos_load_value(pos_load_value),
        .stop_left(stop_left), .stop_right(stop_right), .home_switch(home_switch),
        .actual_pos(actual_pos), .enc_step(enc_step), .enc_up(enc_up));

    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Classic single cycle; read data is taken at the edge that sees ack
    task bus(input we, input [5:0] idx, input [31:0] d);
        integer n;
        begin
            @(posedge sys_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= {idx, 2'b00};
            wb_dat_i <= d;
            n = 0;
            @(posedge sys_clk);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            if (n == 20)
                n_fail = n_fail + 1;
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task rdchk(input [5:0] idx, input [31:0] exp);
        begin
            bus(1'b0, idx, 32'h0);
            chk(rd, exp);
        end
    endtask

    task cmd(input [1:0] c);
        bus(1'b1, `ADR_COMMAND, {22'h0, c, `CMD_OPCODE});
    endtask

    task wait_done;
        integer n;
        begin
            n = 0;
            rd = 32'h0;
            while (rd[1:0] !== 2'b10 && n < 4000) begin
                bus(1'b0, `ADR_STATUS, 32'h0);
                n = n + 1;
            end
            if (n == 4000)
                n_fail = n_fail + 1;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #(40 * 60000);
        n_fail = n_fail + 1;
        summarize;
    end

    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        n_fail = 0;
        n_checks = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(`ADR_STATUS, 32'h10);
        rdchk(`ADR_MODE, {24'h0, `RST_MODE});
        rdchk(`ADR_SEARCH_VEL, `RST_SEARCH_VEL);
        rdchk(`ADR_CAL_VEL, `RST_CAL_VEL);
        rdchk(`ADR_FULL_STEPS, 32'd200);
        rdchk(`ADR_ENC_CPR, `RST_ENC_CPR);
        rdchk(`ADR_MAX_DEV, 32'h0);
        rdchk(6'h20, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            bus(1'b1, `ADR_MODE, (i == 0) ? 32'h0 : ((i == 1) ? 32'h9 : 32'h45));
            cmd(`CMD_START);
            rdchk(`ADR_STATUS, 32'h14);
        end
        cmd(`CMD_STATUS);
        rdchk(`ADR_STATUS, 32'h14);
        // Limit auto-stop armed on purpose: it must stay quiet while searching
        bus(1'b1, `ADR_STOP_ENABLE, 32'h3);
        bus(1'b1, `ADR_MODE, 32'h1);
        cmd(`CMD_START);
        repeat (2) @(posedge sys_clk);
        chk(motor_dir, 1'b0);
        rdchk(`ADR_STATUS, 32'h21);
        wait_done;
        chk(rd[1:0], 2'b10);
        chk(pos_load_value, 32'hffff_fffe);
        rdchk(`ADR_ENC_POS, 32'h0);
        chk(motor_halt, 1'b1);
        bus(1'b1, `ADR_STOP_ENABLE, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(motor_halt, 1'b0);
        bus(1'b1, `ADR_MODE, 32'h2);
        cmd(`CMD_START);
        repeat (2) @(posedge sys_clk);
        chk(motor_dir, 1'b1);
        wait_done;
        rdchk(`ADR_SWITCH_DIST, 32'd36);
        chk(pos_load_value, 32'hffff_fffe);
        bus(1'b1, `ADR_FULL_STEPS, 32'd100);
        rdchk(`ADR_FULL_STEPS, 32'd100);
        bus(1'b1, `ADR_ENC_POS, 32'h0);
        p0 = i_axis.phys;
        bus(1'b1, `ADR_MODE, 32'd65);
        cmd(`CMD_START);
        repeat (200) @(posedge sys_clk);
        cmd(`CMD_STOP);
        repeat (10) @(posedge sys_clk);
        chk(motor_run, 1'b0);
        rdchk(`ADR_ENC_POS, (i_axis.phys - p0) / 2);
        for (i = 0; i < 16; i = i + 1) begin
            b = i / 2 + 1;
            v = i % 2;
            bus(1'b1, `ADR_MODE, b + (v ? ((b < 5) ? 64 : 128) : 0));
            cmd(`CMD_START);
            repeat (2) @(posedge sys_clk);
            chk(motor_run, 1'b1);
            if (!(v && b > 4))
                chk(motor_dir, dir_tab[b - 1] ^ (v == 1));
            cmd(`CMD_STOP);
            rdchk(`ADR_STATUS, 32'h10);
        end
        bus(1'b1, `ADR_MAX_DEV, 32'h4);
        bus(1'b1, `ADR_ENC_POS, 32'h1000);
        repeat (4) @(posedge sys_clk);
        chk(motor_halt, 1'b1);
        bus(1'b0, `ADR_STATUS, 32'h0);
        chk(rd[3], 1'b1);
        summarize;
    end
endmodule // tb_top
